/* File: rtl/atb_pkg.sv */
// Package: constants, layouts and types of the ADC-triggered block transfer controller
// Operation
// - Request plus enable: acquire bus first
// - Intercepted request never reaches CPU interrupt
// - Vector at base plus 400h plus number*4
// - Read control information sequentially from vector
// - Control information sets size, source, destination
// - Block mode moves all four results
// - Reading result register clears end flag; code clears it at the first writeback access instead
// - Advance destination, write control information back
// - Release bus only after writeback completes
// - Final block clears enable; next reaches CPU
// - Count A: size high, position low; B blocks
// - Control registers loaded from RAM, not CPU
package atb_pkg;
  localparam int          ADDR_W          = 32;
  localparam int          DATA_W          = 32;
  localparam logic [31:0] VEC_TABLE_OFS   = 32'h0000_0400;
  localparam logic [31:0] VEC_STRIDE      = 32'h0000_0004;
  localparam logic [7:0]  VEC_NUM_DEFAULT = 8'h40;  // Arbitrary default source number
  // Control information words, in RAM order
  localparam int          CI_WORDS        = 4;
  localparam logic [1:0]  CI_MODE_IDX     = 2'h0;
  localparam logic [1:0]  CI_SRC_IDX      = 2'h1;
  localparam logic [1:0]  CI_DST_IDX      = 2'h2;
  localparam logic [1:0]  CI_CNT_IDX      = 2'h3;
  // Mode word field positions
  localparam int          MODE_MD_LSB     = 30;
  localparam int          MODE_SZ_LSB     = 28;
  localparam logic [1:0]  MD_BLOCK        = 2'h2;
  // Count word: count A in upper half, count B in lower half
  localparam int          CNT_A_LSB       = 16;
  localparam int          CNT_B_LSB       = 0;
  // Register port offsets and reset values
  localparam logic [3:0]  REG_CTRL        = 4'h0;
  localparam logic [3:0]  REG_VBASE       = 4'h4;
  localparam logic [3:0]  REG_STAT        = 4'h8;
  localparam logic [3:0]  REG_MASK        = 4'hc;
  localparam int          CTRL_EN_BIT     = 0;
  localparam int          EV_BLOCK_BIT    = 0;
  localparam int          EV_DONE_BIT     = 1;
  localparam logic [31:0] VBASE_RESET     = 32'h0000_0000;
  localparam logic [1:0]  EV_RESET        = 2'h0;

  typedef struct packed {
    logic              req;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        size;
  } atb_bus_req_t;

  typedef struct packed {
    logic              gnt;
    logic              ack;
    logic [DATA_W-1:0] rdata;
  } atb_bus_rsp_t;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b000_0001,
    ST_ARB   = 7'b000_0010,
    ST_VEC   = 7'b000_0100,
    ST_CI    = 7'b000_1000,
    ST_RD    = 7'b001_0000,
    ST_WR    = 7'b010_0000,
    ST_WB    = 7'b100_0000
  } atb_state_t;
endpackage : atb_pkg

/* File: rtl/atb_ctrl.sv */
// Transfer controller activated by the converter's conversion-end request
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
module atb_ctrl #(
  parameter logic [7:0] VEC_NUM = atb_pkg::VEC_NUM_DEFAULT
) (
  input  wire logic                    mclk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    conversion_end_request_i,
  output logic                         conversion_end_flag_clr_o,
  output logic                         cpu_conv_irq_o,
  output atb_pkg::atb_bus_req_t        bus_req_o,
  input  wire atb_pkg::atb_bus_rsp_t   bus_rsp_i,
  input  wire logic [3:0]              reg_addr_i,
  input  wire logic [31:0]             reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic [31:0]                  reg_rdata_o,
  output logic                         irq_o
);
  import atb_pkg::*;

  atb_state_t        state;
  logic              source_transfer_enable;
  logic [31:0]       vector_base;
  logic [1:0]        ev_stat;
  logic [1:0]        ev_mask;
  // Working copies of the control information, never visible to software
  logic [31:0]       mode_word;
  logic [31:0]       src_addr;
  logic [31:0]       dst_addr;
  logic [7:0]        block_size_byte;
  logic [7:0]        block_position_counter;
  logic [15:0]       block_count;
  logic [31:0]       ci_ptr;
  logic [1:0]        ci_idx;
  logic [31:0]       data_hold;
  logic              ev_block;
  logic              ev_done;
  logic [31:0]       unit_bytes;
  logic [31:0]       vec_addr;
  logic              is_final;
  logic [15:0]       next_count_b;

  // Unit byte size from the loaded mode word
  always_comb begin
    case (mode_word[MODE_SZ_LSB +: 2])
      2'h0:    unit_bytes = 32'h0000_0001;
      2'h1:    unit_bytes = 32'h0000_0002;
      default: unit_bytes = 32'h0000_0004;
    endcase
  end

  assign vec_addr     = vector_base + VEC_TABLE_OFS + ({24'h00_0000, VEC_NUM} * VEC_STRIDE);
  // Last block of the job; the count was already stepped when writeback runs
  assign is_final     = (block_count == 16'h0000);
  assign next_count_b = block_count - 16'h0001;

  // Sequencer; each bus step waits for ack, so RAM latency is free
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (conversion_end_request_i && source_transfer_enable) begin
            state <= ST_ARB;
          end
        end
        ST_ARB: begin
          if (bus_rsp_i.gnt) begin
            state <= ST_VEC;
          end
        end
        ST_VEC: begin
          if (bus_rsp_i.ack) begin
            state <= ST_CI;
          end
        end
        ST_CI: begin
          if (bus_rsp_i.ack && ci_idx == 2'(CI_WORDS - 1)) begin
            state <= ST_RD;
          end
        end
        ST_RD: begin
          if (bus_rsp_i.ack) begin
            state <= ST_WR;
          end
        end
        ST_WR: begin
          if (bus_rsp_i.ack) begin
            if (block_position_counter == 8'h01 || block_position_counter == 8'h00) begin
              state <= ST_WB;
            end else begin
              state <= ST_RD;
            end
          end
        end
        ST_WB: begin
          if (bus_rsp_i.ack && ci_idx == 2'(CI_WORDS - 1)) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Control information pointer and word index
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ci_ptr <= 32'h0000_0000;
      ci_idx <= 2'h0;
    end else if (state == ST_VEC && bus_rsp_i.ack) begin
      ci_ptr <= bus_rsp_i.rdata;
      ci_idx <= 2'h0;
    end else if ((state == ST_CI || state == ST_WB) && bus_rsp_i.ack) begin
      ci_idx <= ci_idx + 2'h1;
    end
  end

  // Load, step and update of the working registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_word              <= 32'h0000_0000;
      src_addr               <= 32'h0000_0000;
      dst_addr               <= 32'h0000_0000;
      block_size_byte        <= 8'h00;
      block_position_counter <= 8'h00;
      block_count            <= 16'h0000;
      data_hold              <= 32'h0000_0000;
    end else if (state == ST_CI && bus_rsp_i.ack) begin
      case (ci_idx)
        CI_MODE_IDX: mode_word <= bus_rsp_i.rdata;
        CI_SRC_IDX:  src_addr  <= bus_rsp_i.rdata;
        CI_DST_IDX:  dst_addr  <= bus_rsp_i.rdata;
        default: begin
          block_size_byte        <= bus_rsp_i.rdata[CNT_A_LSB+8 +: 8];
          block_position_counter <= bus_rsp_i.rdata[CNT_A_LSB +: 8];
          block_count            <= bus_rsp_i.rdata[CNT_B_LSB +: 16];
        end
      endcase
    end else if (state == ST_RD && bus_rsp_i.ack) begin
      data_hold <= bus_rsp_i.rdata;
      src_addr  <= src_addr + unit_bytes;
    end else if (state == ST_WR && bus_rsp_i.ack) begin
      dst_addr <= dst_addr + unit_bytes;
      if (block_position_counter == 8'h01 || block_position_counter == 8'h00) begin
        // Block done: reload position, rewind source to the first result
        block_position_counter <= block_size_byte;
        src_addr    <= src_addr - unit_bytes * {24'h00_0000, block_size_byte};
        block_count <= next_count_b;
      end else begin
        block_position_counter <= block_position_counter - 8'h01;
      end
    end
  end

  // Bus master outputs; address chosen by step
  always_comb begin
    bus_req_o       = '0;
    bus_req_o.size  = 2'h2;
    case (state)
      ST_ARB: begin
        bus_req_o.req = 1'b1;
      end
      ST_VEC: begin
        bus_req_o.req  = 1'b1;
        bus_req_o.addr = vec_addr;
      end
      ST_CI: begin
        bus_req_o.req  = 1'b1;
        bus_req_o.addr = ci_ptr + {28'h000_0000, ci_idx, 2'h0};
      end
      ST_RD: begin
        bus_req_o.req  = 1'b1;
        bus_req_o.addr = src_addr;
        bus_req_o.size = mode_word[MODE_SZ_LSB +: 2];
      end
      ST_WR: begin
        bus_req_o.req   = 1'b1;
        bus_req_o.we    = 1'b1;
        bus_req_o.addr  = dst_addr;
        bus_req_o.wdata = data_hold;
        bus_req_o.size  = mode_word[MODE_SZ_LSB +: 2];
      end
      ST_WB: begin
        bus_req_o.req  = 1'b1;
        bus_req_o.we   = 1'b1;
        bus_req_o.addr = ci_ptr + {28'h000_0000, ci_idx, 2'h0};
        case (ci_idx)
          CI_MODE_IDX: bus_req_o.wdata = mode_word;
          CI_SRC_IDX:  bus_req_o.wdata = src_addr;
          CI_DST_IDX:  bus_req_o.wdata = dst_addr;
          default:     bus_req_o.wdata = {block_size_byte, block_position_counter, block_count};
        endcase
      end
      default: bus_req_o.req = 1'b0;
    endcase
  end

  // Clear end flag once the block's results have been read
  assign conversion_end_flag_clr_o = (state == ST_WB) && (ci_idx == 2'h0) && bus_rsp_i.ack;

  // Request passes to the CPU only when not intercepted
  assign cpu_conv_irq_o = conversion_end_request_i && !source_transfer_enable
                          && (state == ST_IDLE);

  assign ev_block = (state == ST_WB) && bus_rsp_i.ack && (ci_idx == 2'(CI_WORDS - 1));
  assign ev_done  = ev_block && is_final;

  // Enable bit: software sets it, the final block clears it
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      source_transfer_enable <= 1'b0;
    end else if (ev_done) begin
      source_transfer_enable <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == REG_CTRL) begin
      source_transfer_enable <= reg_wdata_i[CTRL_EN_BIT];
    end
  end

  // Vector base and mask registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vector_base <= VBASE_RESET;
      ev_mask     <= EV_RESET;
    end else if (reg_wr_i) begin
      if (reg_addr_i == REG_VBASE) begin
        vector_base <= reg_wdata_i;
      end
      if (reg_addr_i == REG_MASK) begin
        ev_mask <= reg_wdata_i[1:0];
      end
    end
  end

  // Sticky events; a set in the clearing cycle wins
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ev_stat <= EV_RESET;
    end else begin
      ev_stat <= (ev_stat & ~((reg_wr_i && reg_addr_i == REG_STAT) ? reg_wdata_i[1:0] : 2'h0))
                 | {ev_done, ev_block};
    end
  end

  assign irq_o = |(ev_stat & ev_mask);

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        REG_CTRL:  reg_rdata_o <= {31'h0, source_transfer_enable};
        REG_VBASE: reg_rdata_o <= vector_base;
        REG_STAT:  reg_rdata_o <= {30'h0, ev_stat};
        REG_MASK:  reg_rdata_o <= {30'h0, ev_mask};
        default:   reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  a_no_cpu_irq_busy: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state != ST_IDLE) |-> !cpu_conv_irq_o) else $error("CPU irq while busy");
  a_req_before_xfer: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state == ST_IDLE && conversion_end_request_i && source_transfer_enable)
    |=> state == ST_ARB) else $error("activation not taken");
  a_vec_address: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state == ST_VEC) |-> bus_req_o.addr == vector_base + 32'h400 + {22'h0, VEC_NUM, 2'h0})
    else $error("bad vector address");
  a_bus_held_wb: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state == ST_WB && !bus_rsp_i.ack) |=> state == ST_WB && bus_req_o.req)
    else $error("bus dropped before writeback");
  a_enable_clears: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ev_done |=> !source_transfer_enable) else $error("enable not cleared");
  a_flag_clear_wb: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    conversion_end_flag_clr_o |-> $past(state) inside {ST_WR, ST_WB})
    else $error("flag cleared outside transfer");
  a_dst_advance: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state == ST_WR && bus_rsp_i.ack) |=> dst_addr == $past(dst_addr) + $past(unit_bytes))
    else $error("destination not advanced");
  a_ignore_disabled: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state == ST_IDLE && !source_transfer_enable) |=> state == ST_IDLE)
    else $error("started while disabled");
endmodule : atb_ctrl

/* File: testbench/atb_partner.sv */
// Partner model: on-chip RAM, converter result registers and the converter request source
`timescale 1ns/10ps
module atb_partner
  import atb_pkg::*;
#(
  parameter int CONV = 40
) (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_n_i,
  input  wire atb_pkg::atb_bus_req_t bus_req_i,
  output atb_pkg::atb_bus_rsp_t      bus_rsp_o,
  input  wire logic                  flag_clr_i,
  input  wire logic                  start_i,
  input  wire logic [3:0]            lat_i,
  output logic                       request_o
);
  logic [31:0] mem [logic [31:0]];
  logic [32:0] plog [$];
  logic [3:0]  wait_n;
  logic [7:0]  conv_n;
  logic [7:0]  cnt;
  logic        req_q;
  logic        gnt_q;

  // Result registers carry the conversion number, so stale blocks are told apart
  function automatic logic [31:0] rd(input logic [31:0] a);
    if (a[31:4] == 28'h000_0300) return 32'h00a0_0000 + {20'h0, conv_n, 4'h0} + 32'(a[3:2]);
    if (mem.exists(a)) return mem[a];
    return ~a;  // Unwritten RAM reads as the inverted address
  endfunction : rd

  // Bus slave: grant follows request, each access acked after lat_i wait cycles.
  // The cycle in which the master first sees grant is still arbitration, so no
  // access is taken until grant has stood for one edge already.
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_rsp_o <= '0;
      wait_n    <= '0;
      gnt_q     <= 1'b0;
    end else begin
      bus_rsp_o.gnt   <= bus_req_i.req;
      gnt_q           <= bus_rsp_o.gnt;
      bus_rsp_o.ack   <= 1'b0;
      bus_rsp_o.rdata <= ~bus_rsp_o.rdata;  // Data lines toggle outside an answer
      if (bus_req_i.req && bus_rsp_o.gnt && gnt_q && !bus_rsp_o.ack) begin
        if (wait_n < lat_i) begin
          wait_n <= wait_n + 4'h1;
        end else begin
          wait_n        <= '0;
          bus_rsp_o.ack <= 1'b1;
          plog.push_back({bus_req_i.we, bus_req_i.addr});
          if (bus_req_i.we) mem[bus_req_i.addr] = bus_req_i.wdata;
          else bus_rsp_o.rdata <= rd(bus_req_i.addr);
        end
      end
    end
  end

  // Converter in continuous scan: a new conversion starts once the end flag is cleared
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_q  <= 1'b0;
      cnt    <= '0;
      conv_n <= '0;
    end else if (flag_clr_i || !start_i) begin
      req_q <= 1'b0;
      cnt   <= '0;
    end else if (!req_q) begin
      if (cnt == CONV[7:0]) begin
        req_q  <= 1'b1;
        conv_n <= conv_n + 8'h1;
      end else begin
        cnt <= cnt + 8'h1;
      end
    end
  end
  assign request_o = req_q & ~flag_clr_i;  // Flag clear drops the request at once
endmodule : atb_partner

/* File: testbench/atb_ctrl_tb_top.sv */
// Testbench: register access, two block activations, then hand-over to the CPU
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module atb_ctrl_tb_top;
  import atb_pkg::*;
  localparam logic [31:0] VBASE = 32'h0000_1000;
  localparam logic [31:0] PTR   = 32'h0000_2000;
  localparam logic [31:0] DST   = 32'h0000_4000;
  localparam logic [31:0] VADDR = VBASE + VEC_TABLE_OFS + {24'h0, VEC_NUM_DEFAULT} * VEC_STRIDE;
  logic         mclk_i    = 1'b0;
  logic         rst_n_i   = 1'b0;
  logic         start_bit = 1'b0;
  logic         en_on     = 1'b0;
  logic [3:0]   lat       = 4'h0;
  logic [3:0]   reg_addr  = 4'h0;
  logic [31:0]  reg_wdata = 32'h0;
  logic         reg_wr    = 1'b0;
  logic         reg_rd    = 1'b0;
  logic [31:0]  reg_rdata;
  logic         conv_req, flag_clr, cpu_irq, irq;
  atb_bus_req_t bus_req;
  atb_bus_rsp_t bus_rsp;
  int           n_errors = 0;
  int           check_count = 0;
  int           n_clr = 0;
  int           i;

  always #5 mclk_i = ~mclk_i;

  atb_ctrl atb_ctrl_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .conversion_end_request_i(conv_req), .conversion_end_flag_clr_o(flag_clr),
    .cpu_conv_irq_o(cpu_irq), .bus_req_o(bus_req), .bus_rsp_i(bus_rsp),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .irq_o(irq));
  atb_partner atb_partner_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req),
    .bus_rsp_o(bus_rsp), .flag_clr_i(flag_clr), .start_i(start_bit), .lat_i(lat),
    .request_o(conv_req));

  // Count flag clears; while enabled activations must never reach the CPU
  always @(posedge mclk_i) if (flag_clr === 1'b1) n_clr++;
  always @(negedge mclk_i) begin
    if (rst_n_i && en_on && n_clr < 2) `CHK(cpu_irq, 1'b0)
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk_i);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk_i);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask : reg_read

  task automatic chk_irq(input logic e);
    @(posedge mclk_i);
    #1;
    `CHK(irq, e)
  endtask : chk_irq

  // Bounded wait for the n-th flag clear and the bus to be released
  task automatic wait_done(input int n);
    int k;
    for (k = 0; k < 3000 && !(n_clr >= n && bus_req.req === 1'b0); k++) @(negedge mclk_i);
    if (k == 3000) begin
      n_errors++;
      $display("Error at %0t: activation did not finish", $time);
      summarize();
    end
  endtask : wait_done

  // One activation is 17 accesses: vector, 4 control reads, 4 read/write pairs, 4 writebacks
  task automatic check_run(input int r);
    logic [31:0] d;
    int          b;
    d = DST + 32'(r * 16);
    b = r * 17;
    `CHK(atb_partner_inst.plog.size(), b + 17)
    `CHK(n_clr, r + 1)
    `CHK(atb_partner_inst.plog[b], {1'b0, VADDR})
    for (int j = 0; j < 4; j++) begin
      `CHK(atb_partner_inst.plog[b + 1 + j], {1'b0, PTR + 32'(4 * j)})
      `CHK(atb_partner_inst.plog[b + 5 + 2 * j], {1'b0, 32'h3000 + 32'(4 * j)})
      `CHK(atb_partner_inst.plog[b + 6 + 2 * j], {1'b1, d + 32'(4 * j)})
      `CHK(atb_partner_inst.mem[d + 32'(4 * j)], 32'h00a0_0000 + 32'((r + 1) * 16 + j))
      `CHK(atb_partner_inst.plog[b + 13 + j], {1'b1, PTR + 32'(4 * j)})
    end
    `CHK(atb_partner_inst.mem[PTR + 32'h8], d + 32'h10)
    `CHK(atb_partner_inst.mem[PTR + 32'hc][15:0], 16'(1 - r))
  endtask : check_run

  initial begin
    // Vector and control information: block mode, longword, block of 4, two blocks
    atb_partner_inst.mem[VADDR]      = PTR;
    atb_partner_inst.mem[PTR]        = 32'ha000_0000;
    atb_partner_inst.mem[PTR + 32'h4] = 32'h0000_3000;
    atb_partner_inst.mem[PTR + 32'h8] = DST;
    atb_partner_inst.mem[PTR + 32'hc] = 32'h0404_0002;
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    reg_read(REG_CTRL, 32'h0);
    reg_read(REG_VBASE, VBASE_RESET);
    reg_read(REG_STAT, 32'h0);
    reg_read(REG_MASK, 32'h0);
    reg_write(4'h2, 32'hffff_ffff);
    reg_read(4'h2, 32'h0);
    reg_write(REG_VBASE, VBASE);
    reg_read(REG_VBASE, VBASE);
    reg_write(REG_MASK, 32'h3);
    reg_write(REG_CTRL, 32'h1);
    en_on     <= 1'b1;
    start_bit <= 1'b1;
    wait_done(1);
    lat <= 4'h3;  // Second activation sees a slow RAM
    check_run(0);
    chk_irq(1'b1);
    reg_read(REG_STAT, 32'h1);
    reg_write(REG_STAT, 32'h1);
    chk_irq(1'b0);
    wait_done(2);
    check_run(1);
    reg_read(REG_STAT, 32'h3);
    reg_read(REG_CTRL, 32'h0);
    for (i = 0; i < 500 && cpu_irq !== 1'b1; i++) @(negedge mclk_i);
    `CHK(cpu_irq, 1'b1)
    repeat (20) @(negedge mclk_i);
    `CHK(bus_req.req, 1'b0)
    `CHK(atb_partner_inst.plog.size(), 34)
    start_bit <= 1'b0;
    repeat (2) @(negedge mclk_i);
    `CHK(cpu_irq, 1'b0)
    reg_write(REG_MASK, 32'h0);
    chk_irq(1'b0);
    reg_write(REG_MASK, 32'h2);
    chk_irq(1'b1);
    reg_write(REG_STAT, 32'h3);
    chk_irq(1'b0);
    summarize();
  end
endmodule : atb_ctrl_tb_top
